/* File: hdl/omd_top.sv */
// Operation
// - motion threshold is scaled by selected g range; default 0.5 g at 8 g.
// - screen orientation changes only while tilt exceeds angle limit.
// - programmed hysteresis separates rotation states, up to 45 degrees.
// - report face up, face down and four screen rotations.
// - upright when |ax| below half-g-scale and ay above cosine-scale limit.
// - near flat, face up or down follows sign of z acceleration.
// - orientation change must persist for the 8-bit count of samples.
// - each orientation debounce count equals one sample period.
// - motion goes active when any filtered axis exceeds the threshold.
// - unlatched mode reports return to inactive.
// - motion state changes qualified by 8-bit count of motion samples.
`timescale 1ns/1ns
module omd_top
  import omd_pkg::*;
(
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  // register port
  input  wire logic       i_reg_wr,
  input  wire logic [7:0] i_reg_addr,
  input  wire logic [7:0] i_reg_wdata,
  output logic      [7:0] o_reg_rdata,
  // control bits held outside this block
  input  wire logic       i_operating_enable,
  input  wire logic       i_range_select_high,
  input  wire logic       i_range_select_low,
  input  wire logic       i_motion_latched,
  input  wire logic       i_motion_ack,
  input  wire logic [7:0] i_orient_debounce_count,
  input  wire logic [7:0] i_motion_debounce_count,
  // orientation sample set, 8-bit at 32 counts per g
  input  wire logic       i_orient_sample,
  input  wire logic [7:0] i_ax,
  input  wire logic [7:0] i_ay,
  input  wire logic [7:0] i_az,
  // motion sample set, high-pass filtered, 8-bit at 2 g scale
  input  wire logic       i_motion_sample,
  input  wire logic [7:0] i_hx,
  input  wire logic [7:0] i_hy,
  input  wire logic [7:0] i_hz,
  // results
  output logic      [2:0] o_orientation,
  output logic            o_orientation_change,
  output logic            o_motion_active,
  output logic            o_motion_event
);
  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0] thr_reg;
  logic [7:0] ang_reg;
  logic [7:0] hys_reg;

  omd_regs u_regs (
    .i_clk                     (i_clk),
    .i_rst_b                   (i_rst_b),
    .i_wr                      (i_reg_wr),
    .i_addr                    (i_reg_addr),
    .i_wdata                   (i_reg_wdata),
    .o_rdata                   (o_reg_rdata),
    .o_motion_threshold        (thr_reg),
    .o_orientation_angle_limit (ang_reg),
    .o_rotation_hysteresis     (hys_reg)
  );

  // ****************************************************************
  // working copies, taken only while the engines are stopped
  // ****************************************************************
  logic [7:0] thr;
  logic [7:0] next_thr;
  logic [7:0] ang;
  logic [7:0] next_ang;
  logic [4:0] hys;
  logic [4:0] next_hys;

  // engines keep the old value while running, so a live write waits for the next stop
  always_comb begin
    next_thr = thr;
    next_ang = ang;
    next_hys = hys;
    if (!i_operating_enable) begin
      next_thr = thr_reg;
      next_ang = ang_reg;
      next_hys = hys_reg[HYST_FIELD_W-1:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      thr <= RST_MOTION_THRESHOLD;
      ang <= RST_ORIENT_ANGLE_LIMIT;
      hys <= RST_ROTATION_HYST[HYST_FIELD_W-1:0];
    end else begin
      thr <= next_thr;
      ang <= next_ang;
      hys <= next_hys;
    end
  end

  // ****************************************************************
  // orientation classifier
  // ****************************************************************
  function automatic logic [7:0] mag(input logic [7:0] v);
    mag = v[7] ? 8'(-v) : v;
  endfunction

  logic [7:0] max_x;
  logic [7:0] max_y;
  logic [7:0] abs_x;
  logic [7:0] abs_y;
  logic [7:0] lim_hi;
  logic [7:0] lim_lo;
  logic [8:0] hys_off;
  omd_orient_t cand;
  omd_orient_t cur;

  // hysteresis widens the band: 15 deg (code 20) gives 0.5 g / 0.866 g
  always_comb begin
    abs_x   = mag(i_ax);
    abs_y   = mag(i_ay);
    max_x   = abs_x;
    max_y   = abs_y;
    hys_off = 9'({4'h0, hys} >> 2);
    lim_lo  = 8'(9'h10 - hys_off + 9'h05); // 16 counts = 0.5 g at default
    lim_hi  = 8'(9'h1C + hys_off - 9'h05); // 28 counts ~ 0.866 g
    cand    = cur;
    if (max_x < ang && max_y < ang) begin
      cand = i_az[7] ? OMD_FACE_DOWN : OMD_FACE_UP;
    end else if (abs_x < lim_lo && !i_ay[7] && abs_y > lim_hi) begin
      cand = OMD_ROT_0;
    end else if (abs_y < lim_lo && !i_ax[7] && abs_x > lim_hi) begin
      cand = OMD_ROT_90;
    end else if (abs_x < lim_lo && i_ay[7] && abs_y > lim_hi) begin
      cand = OMD_ROT_180;
    end else if (abs_y < lim_lo && i_ax[7] && abs_x > lim_hi) begin
      cand = OMD_ROT_270;
    end
  end

  logic [2:0] orient_raw;

  omd_debounce #(.W(3)) u_orient_db (
    .i_clk         (i_clk),
    .i_rst_b       (i_rst_b),
    .i_sample      (i_orient_sample && i_operating_enable),
    .i_cand        (cand),
    .i_count       (i_orient_debounce_count),
    .i_reset_state (3'h0),
    .o_state       (orient_raw),
    .o_change      (o_orientation_change)
  );

  assign cur           = omd_orient_t'(orient_raw);
  assign o_orientation = orient_raw;

  // ****************************************************************
  // motion engine
  // ****************************************************************
  logic [7:0] thr_scaled;
  logic       over;

  // sample data are at 2 g scale; wider ranges mean larger steps per code
  always_comb begin
    case ({i_range_select_high, i_range_select_low})
      RANGE_2G: thr_scaled = thr;
      RANGE_4G: thr_scaled = (thr > 8'h7F) ? 8'hFF : 8'(thr << 1);
      RANGE_8G: thr_scaled = (thr > 8'h3F) ? 8'hFF : 8'(thr << 2);
      default:  thr_scaled = thr;
    endcase
    over = mag(i_hx) > thr_scaled || mag(i_hy) > thr_scaled
        || mag(i_hz) > thr_scaled;
  end

  logic       mot_state;
  logic       mot_chg;
  logic       ind;
  logic       next_ind;
  logic       evt;
  logic       next_evt;

  omd_debounce #(.W(1)) u_motion_db (
    .i_clk         (i_clk),
    .i_rst_b       (i_rst_b),
    .i_sample      (i_motion_sample && i_operating_enable),
    .i_cand        (over),
    .i_count       (i_motion_debounce_count),
    .i_reset_state (1'b0),
    .o_state       (mot_state),
    .o_change      (mot_chg)
  );

  // a new activation beats an acknowledge in the same cycle
  always_comb begin
    next_ind = ind;
    next_evt = 1'b0;
    if (i_motion_latched) begin
      if (i_motion_ack) next_ind = 1'b0;
      if (mot_chg && mot_state) begin
        next_ind = 1'b1;
        next_evt = 1'b1;
      end
    end else begin
      next_ind = mot_state;
      next_evt = mot_chg;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ind <= 1'b0;
      evt <= 1'b0;
    end else begin
      ind <= next_ind;
      evt <= next_evt;
    end
  end

  assign o_motion_active = ind;
  assign o_motion_event  = evt;

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_copy_frozen;
    @(posedge i_clk) disable iff (!i_rst_b)
      $past(i_operating_enable) |-> thr == $past(thr);
  endproperty
  a_copy_frozen: assert property (p_copy_frozen)
    else $error("threshold copy changed while running");

  property p_latched_hold;
    @(posedge i_clk) disable iff (!i_rst_b)
      i_motion_latched && ind && !i_motion_ack ##1 i_motion_latched
        |-> ind;
  endproperty
  a_latched_hold: assert property (p_latched_hold)
    else $error("latched motion dropped without acknowledge");

  property p_unlatched_follow;
    @(posedge i_clk) disable iff (!i_rst_b)
      !i_motion_latched |=> ind == $past(mot_state);
  endproperty
  a_unlatched_follow: assert property (p_unlatched_follow)
    else $error("unlatched motion does not follow state");

  property p_flat_face;
    @(posedge i_clk) disable iff (!i_rst_b)
      abs_x < ang && abs_y < ang |->
        (cand == OMD_FACE_UP || cand == OMD_FACE_DOWN);
  endproperty
  a_flat_face: assert property (p_flat_face)
    else $error("flat device not classed face up or down");

  property p_change_pulse;
    @(posedge i_clk) disable iff (!i_rst_b)
      o_orientation_change
        |-> $past(i_orient_sample) && $past(i_operating_enable);
  endproperty
  a_change_pulse: assert property (p_change_pulse)
    else $error("orientation change without an orientation sample");

  // a motion state change needs a motion sample taken while running
  property p_motion_cause;
    @(posedge i_clk) disable iff (!i_rst_b)
      mot_chg |-> $past(i_motion_sample) && $past(i_operating_enable);
  endproperty
  a_motion_cause: assert property (p_motion_cause)
    else $error("motion state changed without a motion sample");

  // a new rotation state only when the tilt was above the limit
  property p_tilt_gate;
    @(posedge i_clk) disable iff (!i_rst_b)
      o_orientation_change && o_orientation > 3'h1
        |-> $past(abs_x >= ang || abs_y >= ang);
  endproperty
  a_tilt_gate: assert property (p_tilt_gate)
    else $error("screen rotated while below the angle limit");

  // two unlatched cycles: any level change carries an event pulse
  property p_unlatched_event;
    @(posedge i_clk) disable iff (!i_rst_b)
      !i_motion_latched ##1 !i_motion_latched ##1 ind != $past(ind)
        |-> evt;
  endproperty
  a_unlatched_event: assert property (p_unlatched_event)
    else $error("unlatched motion change without an event");

  // wide range must saturate, never wrap below the raw code
  property p_range_sat;
    @(posedge i_clk) disable iff (!i_rst_b)
      {i_range_select_high, i_range_select_low} == RANGE_8G
        |-> thr_scaled >= thr;
  endproperty
  a_range_sat: assert property (p_range_sat)
    else $error("scaled motion threshold wrapped");

  c_motion: cover property (@(posedge i_clk) disable iff (!i_rst_b)
    $rose(ind));
  c_orient: cover property (@(posedge i_clk) disable iff (!i_rst_b)
    o_orientation_change);
  c_ack: cover property (@(posedge i_clk) disable iff (!i_rst_b)
    $fell(ind) && i_motion_latched);
endmodule

/* File: hdl/omd_pkg.sv */
package omd_pkg;
  // register addresses on the serial register port
  localparam logic [7:0] OFS_MOTION_THRESHOLD   = 8'h5A;
  localparam logic [7:0] OFS_ORIENT_ANGLE_LIMIT = 8'h5C;
  localparam logic [7:0] OFS_ROTATION_HYST      = 8'h5F;
  // reset values
  localparam logic [7:0] RST_MOTION_THRESHOLD   = 8'h08;
  localparam logic [7:0] RST_ORIENT_ANGLE_LIMIT = 8'h0C;
  localparam logic [7:0] RST_ROTATION_HYST      = 8'h14;
  // hysteresis field layout: low five bits, upper three trim
  localparam int HYST_FIELD_W   = 5;
  localparam int TRIM_LSB       = 5;
  // orientation angle limit scale, counts per g
  localparam logic [7:0] ANGLE_SCALE_CPG = 8'h20;
  // hysteresis reset field (0x14) corresponds to 15 degrees
  localparam int HYST_RESET_DEG = 15;
  localparam int HYST_MAX_DEG   = 45;
  // threshold scales with range: shift of the 8-bit code per range
  localparam logic [1:0] RANGE_2G = 2'h0;
  localparam logic [1:0] RANGE_4G = 2'h1;
  localparam logic [1:0] RANGE_8G = 2'h2;
  // orientation report codes
  typedef enum logic [2:0] {
    OMD_FACE_UP, OMD_FACE_DOWN, OMD_ROT_0, OMD_ROT_90, OMD_ROT_180,
    OMD_ROT_270
  } omd_orient_t;
endpackage

/* File: hdl/omd_debounce.sv */
`timescale 1ns/1ns
// counts consecutive qualifying samples before accepting a new state
module omd_debounce
  import omd_pkg::*;
#(
  parameter int W = 3
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst_b,
  // sample strobe and candidate
  input  wire logic         i_sample,
  input  wire logic [W-1:0] i_cand,
  input  wire logic [7:0]   i_count,
  input  wire logic [W-1:0] i_reset_state,
  // accepted state
  output logic      [W-1:0] o_state,
  output logic              o_change
);
  logic [W-1:0] state;
  logic [W-1:0] next_state;
  logic [W-1:0] pend;
  logic [W-1:0] next_pend;
  logic [7:0]   cnt;
  logic [7:0]   next_cnt;
  logic         chg;
  logic         next_chg;

  // widths below one bit cannot hold a state
  if (W < 1) begin : g_bad_width
    $error("debounce state width must be at least one bit");
  end

  // counter restarts whenever the candidate wavers, so a change must persist
  always_comb begin
    next_state = state;
    next_pend  = pend;
    next_cnt   = cnt;
    next_chg   = 1'b0;
    if (i_sample) begin
      if (i_cand == state) begin
        next_cnt  = 8'h00;
        next_pend = state;
      end else if (i_cand != pend) begin
        next_pend = i_cand;
        next_cnt  = 8'h01;
        if (i_count <= 8'h01) begin
          next_state = i_cand;
          next_chg   = 1'b1;
          next_cnt   = 8'h00;
        end
      end else if (cnt + 8'h01 >= i_count) begin
        next_state = pend;
        next_chg   = 1'b1;
        next_cnt   = 8'h00;
      end else begin
        next_cnt = cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= '0;
      pend  <= '0;
      cnt   <= 8'h00;
      chg   <= 1'b0;
    end else begin
      state <= next_state;
      pend  <= next_pend;
      cnt   <= next_cnt;
      chg   <= next_chg;
    end
  end

  assign o_state  = state ^ i_reset_state;
  assign o_change = chg;
endmodule

/* File: hdl/omd_regs.sv */
`timescale 1ns/1ns
// the three configuration registers of the detection engines
module omd_regs
  import omd_pkg::*;
(
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  // register port
  input  wire logic       i_wr,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  output logic      [7:0] o_rdata,
  // register contents
  output logic      [7:0] o_motion_threshold,
  output logic      [7:0] o_orientation_angle_limit,
  output logic      [7:0] o_rotation_hysteresis
);
  logic [7:0] thr;
  logic [7:0] next_thr;
  logic [7:0] ang;
  logic [7:0] next_ang;
  logic [7:0] hys;
  logic [7:0] next_hys;
  logic [7:0] rd;
  logic [7:0] next_rd;

  // decode writes; unmapped addresses read as zero
  always_comb begin
    next_thr = thr;
    next_ang = ang;
    next_hys = hys;
    if (i_wr && i_addr == OFS_MOTION_THRESHOLD)   next_thr = i_wdata;
    if (i_wr && i_addr == OFS_ORIENT_ANGLE_LIMIT) next_ang = i_wdata;
    if (i_wr && i_addr == OFS_ROTATION_HYST)      next_hys = i_wdata;
    case (i_addr)
      OFS_MOTION_THRESHOLD:   next_rd = thr;
      OFS_ORIENT_ANGLE_LIMIT: next_rd = ang;
      OFS_ROTATION_HYST:      next_rd = hys;
      default:                next_rd = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      thr <= RST_MOTION_THRESHOLD;
      ang <= RST_ORIENT_ANGLE_LIMIT;
      hys <= RST_ROTATION_HYST;
      rd  <= 8'h00;
    end else begin
      thr <= next_thr;
      ang <= next_ang;
      hys <= next_hys;
      rd  <= next_rd;
    end
  end

  assign o_rdata                   = rd;
  assign o_motion_threshold        = thr;
  assign o_orientation_angle_limit = ang;
  assign o_rotation_hysteresis     = hys;
endmodule

/* File: verification/omd_host.sv */
`timescale 1ns/1ns
// host model: sets up the detection engines over the register port
module omd_host
  import omd_pkg::*;
(
  // clock
  input  wire logic       i_clk,
  // register port
  input  wire logic [7:0] i_rdata,
  output logic            o_wr,
  output logic      [7:0] o_addr,
  output logic      [7:0] o_wdata,
  output logic            o_operating_enable
);
  // idle bus, engines running
  initial begin
    o_wr = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
    o_operating_enable = 1'b1;
  end

  // engines paused first so the new value is taken cleanly
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk) #1;
    o_operating_enable = 1'b0;
    @(posedge i_clk) #1;
    o_wr = 1'b1;
    o_addr = a;
    o_wdata = d;
    @(posedge i_clk) #1;
    o_wr = 1'b0;
    @(posedge i_clk) #1;
    @(posedge i_clk) #1;
    o_operating_enable = 1'b1;
  endtask

  // read data follows the address by one cycle
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk) #1;
    o_addr = a;
    @(posedge i_clk);
    @(posedge i_clk) #1;
    d = i_rdata;
  endtask

  // trim bits are factory values, so merge rather than overwrite
  task automatic write_hyst(input logic [4:0] f);
    logic [7:0] cur;
    read_reg(OFS_ROTATION_HYST, cur);
    write_reg(OFS_ROTATION_HYST, {cur[7:5], f});
  endtask
endmodule

/* File: verification/tb_orientation_motion_detect.sv */
`timescale 1ns/1ns
module tb_orientation_motion_detect;
  import omd_pkg::*;
  // ****************
  // signals
  // ****************
  logic       clk;
  logic       rst_b;
  logic       wr;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       en;
  logic       rhi;
  logic       rlo;
  logic       latched;
  logic       ack;
  logic [7:0] odb;
  logic [7:0] mdb;
  logic       os;
  logic       ms;
  logic [7:0] ax, ay, az, hx, hy, hz;
  logic [2:0] orient;
  logic       ochg;
  logic       mact;
  logic       mevt;
  logic       seen_chg;
  logic       seen_evt;
  logic [7:0] rd;
  int         fail_count;
  int         cmp_count;

  omd_host omd_host_inst (.i_clk(clk), .i_rdata(rdata), .o_wr(wr),
    .o_addr(addr), .o_wdata(wdata), .o_operating_enable(en));

  omd_top omd_top_inst (.i_clk(clk), .i_rst_b(rst_b), .i_reg_wr(wr),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .i_operating_enable(en), .i_range_select_high(rhi),
    .i_range_select_low(rlo), .i_motion_latched(latched),
    .i_motion_ack(ack), .i_orient_debounce_count(odb),
    .i_motion_debounce_count(mdb), .i_orient_sample(os), .i_ax(ax),
    .i_ay(ay), .i_az(az), .i_motion_sample(ms), .i_hx(hx), .i_hy(hy),
    .i_hz(hz), .o_orientation(orient), .o_orientation_change(ochg),
    .o_motion_active(mact), .o_motion_event(mevt));

  // 100 ns period
  always begin
    #50 clk = ~clk;
  end

  // ****************
  // shared tasks
  // ****************
  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %0h, seen %0h", n, e, g);
    end
  endtask

  // one sample set; pulses are caught over the next three cycles
  task automatic smp(input bit mot, input logic [7:0] x, y, z);
    integer k;
    @(posedge clk) #1;
    if (mot) begin
      hx = x;
      hy = y;
      hz = z;
      ms = 1'b1;
    end else begin
      ax = x;
      ay = y;
      az = z;
      os = 1'b1;
    end
    @(posedge clk) #1;
    ms = 1'b0;
    os = 1'b0;
    seen_chg = 1'b0;
    seen_evt = 1'b0;
    for (k = 0; k < 3; k++) begin
      seen_chg |= ochg;
      seen_evt |= mevt;
      @(posedge clk) #1;
    end
  endtask

  // orientation sample, then expected pulse and state
  task automatic osmp(input logic [7:0] x, y, z, input logic c,
                      input omd_orient_t e);
    smp(1'b0, x, y, z);
    chk("orient change", 8'(c), 8'(seen_chg));
    chk("orientation", 8'(e), 8'(orient));
  endtask

  // motion sample, then expected event and level
  task automatic msmp(input logic [7:0] x, input logic v, input logic a);
    smp(1'b1, x, 8'h00, 8'h00);
    chk("motion event", 8'(v), 8'(seen_evt));
    chk("motion active", 8'(a), 8'(mact));
  endtask

  task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ****************
  // scenarios
  // ****************
  // reset values, unmapped hole, trim bits kept
  task automatic t_regs;
    omd_host_inst.read_reg(OFS_MOTION_THRESHOLD, rd);
    chk("threshold reset", 8'h08, rd);
    omd_host_inst.read_reg(OFS_ORIENT_ANGLE_LIMIT, rd);
    chk("angle reset", 8'h0C, rd);
    omd_host_inst.read_reg(OFS_ROTATION_HYST, rd);
    chk("hyst reset", 8'h14, rd);
    omd_host_inst.read_reg(8'h5B, rd);
    chk("unmapped", 8'h00, rd);
    // sin 30 deg at 32 counts per g
    omd_host_inst.write_reg(OFS_ORIENT_ANGLE_LIMIT, 8'h10);
    omd_host_inst.read_reg(OFS_ORIENT_ANGLE_LIMIT, rd);
    chk("angle", 8'h10, rd);
    omd_host_inst.write_hyst(5'h0A);
    omd_host_inst.read_reg(OFS_ROTATION_HYST, rd);
    chk("hyst", 8'h0A, rd);
  endtask

  // every state once, each step a real change except the two kept-state checks
  task automatic t_orient;
    osmp(8'h00, 8'h00, 8'hE0, 1'b1, OMD_FACE_DOWN);
    // passes only with the narrower band of hysteresis code 0x0A
    osmp(8'h12, 8'h1B, 8'h00, 1'b1, OMD_ROT_0);
    osmp(8'h20, 8'h00, 8'h00, 1'b1, OMD_ROT_90);
    osmp(8'h00, 8'hE0, 8'h00, 1'b1, OMD_ROT_180);
    osmp(8'hE0, 8'h00, 8'h00, 1'b1, OMD_ROT_270);
    // tilted past the limit but outside every band: state is kept
    osmp(8'hEE, 8'h00, 8'h1E, 1'b0, OMD_ROT_270);
    osmp(8'h00, 8'h00, 8'h20, 1'b1, OMD_FACE_UP);
    // tilt below the angle limit must not rotate
    osmp(8'h00, 8'h08, 8'h1E, 1'b0, OMD_FACE_UP);
  endtask

  // a new state must persist for the whole count
  task automatic t_debounce;
    odb = 8'h03;
    osmp(8'h00, 8'h20, 8'h00, 1'b0, OMD_FACE_UP);
    osmp(8'h00, 8'h20, 8'h00, 1'b0, OMD_FACE_UP);
    osmp(8'h00, 8'h20, 8'h00, 1'b1, OMD_ROT_0);
    odb = 8'h00;
    osmp(8'h00, 8'h00, 8'h20, 1'b1, OMD_FACE_UP);
  endtask

  // unlatched: start and end both reported, each debounced
  task automatic t_motion;
    mdb = 8'h02;
    msmp(8'h07, 1'b0, 1'b0);
    msmp(8'h09, 1'b0, 1'b0);
    msmp(8'h09, 1'b1, 1'b1);
    msmp(8'h00, 1'b0, 1'b1);
    msmp(8'h00, 1'b1, 1'b0);
    mdb = 8'h00;
  endtask

  // latched: indication held until acknowledged
  task automatic t_latched;
    latched = 1'b1;
    msmp(8'h09, 1'b1, 1'b1);
    msmp(8'h00, 1'b0, 1'b1);
    @(posedge clk) #1;
    ack = 1'b1;
    @(posedge clk) #1;
    ack = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("active after ack", 8'h00, 8'(mact));
    latched = 1'b0;
  endtask

  // threshold scales with the selected range
  task automatic t_range;
    rhi = 1'b1;
    msmp(8'h14, 1'b0, 1'b0);
    msmp(8'h28, 1'b1, 1'b1);
    msmp(8'h00, 1'b1, 1'b0);
    rhi = 1'b0;
    rlo = 1'b1;
    msmp(8'h14, 1'b1, 1'b1);
    msmp(8'h00, 1'b1, 1'b0);
    rlo = 1'b0;
  endtask

  // a quarter g at the 2 g data scale, written while stopped
  task automatic t_thresh;
    omd_host_inst.write_reg(OFS_MOTION_THRESHOLD, 8'h10);
    msmp(8'h10, 1'b0, 1'b0);
    msmp(8'h11, 1'b1, 1'b1);
    msmp(8'h00, 1'b1, 1'b0);
  endtask

  // ****************
  // main sequence
  // ****************
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    {rhi, rlo, latched, ack, os, ms} = 6'h00;
    {odb, mdb, ax, ay, az, hx, hy, hz} = 64'h0;
    fail_count = 0;
    cmp_count = 0;
    repeat (3) @(posedge clk);
    #1;
    rst_b = 1'b1;
    chk("orient reset", 8'(OMD_FACE_UP), 8'(orient));
    t_regs();
    t_orient();
    t_debounce();
    t_motion();
    t_latched();
    t_range();
    t_thresh();
    end_of_test();
  end

  // a hang counts as a mismatch
  initial begin
    #2000000;
    fail_count++;
    end_of_test();
  end
endmodule
